// File: prg_pkg.sv
// ==========================================================================
// Summary of operation
// RULE_01: Total failure test at start; failure blocks output
// RULE_02: Withhold words built from post-failure raw bits
// RULE_03: Online test runs at start-up and operation
// RULE_04: Output blocked until start-up test passes
// RULE_05: Online test continuous, detects defects in bounded time
// RULE_06: Words delivered 8 or 16 bits wide
// RULE_07: Raw bits passed unprocessed, keeping entropy quality
// RULE_08: Fault sets sticky alarm, drops output valid
// ==========================================================================
package prg_pkg;

  // ========================================================================
  // Widths
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int NARROW_W = 8;

  // ========================================================================
  // Total failure test: longest run of one raw value tolerated
  localparam int STUCK_NS = 640;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STUCK_CYC = STUCK_NS / CLK_PERIOD_NS;
  localparam int STUCK_CNT_W = 8;

  // ========================================================================
  // Online test: ones count over a window must lie inside bounds
  localparam int WIN_BITS = 256;
  localparam int WIN_CNT_W = 9;
  localparam logic [WIN_CNT_W-1:0] WIN_LAST = 9'h0ff;
  localparam logic [WIN_CNT_W-1:0] ONES_LO = 9'h060;
  localparam logic [WIN_CNT_W-1:0] ONES_HI = 9'h0a0;

  // ========================================================================
  // Health state, Gray coded along start-up, run, fault
  typedef enum logic [1:0] {
    PRG_STARTUP = 2'b00,
    PRG_RUN = 2'b01,
    PRG_FAULT = 2'b11
  } prg_state_t;

  // Word carried through the buffer
  typedef struct packed {
    logic wide;
    logic [WORD_W-1:0] data;
  } prg_word_t;

  localparam int PW_W = $bits(prg_word_t);

endpackage

// File: prg_health_gate.sv
`timescale 1ns/1ps

// ==========================================================================
// Word buffer with flush
module prg_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic flush,
  // Fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0] wp_r, wp_nxt;  // Write pointer
  logic [AW-1:0] rp_r, rp_nxt;  // Read pointer
  logic [AW:0] cnt_r, cnt_nxt;  // Fill level
  logic do_wr;
  logic do_rd;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // Pointer and level update
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      // Drop everything held
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (do_wr) wp_nxt = wp_r + 1'b1;
      if (do_rd) rp_nxt = rp_r + 1'b1;
      if (do_wr && !do_rd) cnt_nxt = cnt_r + 1'b1;
      else if (do_rd && !do_wr) cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (do_wr && !flush) mem[wp_r] <= in_data;
  end
endmodule

// ==========================================================================
// Health-gated random word source
module prg_health_gate
  import prg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Entropy source pin
  input wire logic raw_bit,
  // Word format and alarm control
  input wire logic wide_mode,
  input wire logic alarm_clr,
  // Random word stream
  output logic [WORD_W-1:0] rnd_data_r,
  output logic rnd_wide_r,
  output logic rnd_valid_r,
  input wire logic rnd_ready,
  // Health status
  output logic alarm_r,
  output logic healthy_r
);
  // ========================================================================
  // Input synchroniser, accepted once stages two and three agree
  logic s1_r, s2_r, s3_r;
  logic bit_r, bit_nxt;  // Accepted raw bit
  logic bit_new;  // Accepted value this cycle
  always_comb begin
    bit_nxt = (s2_r == s3_r) ? s3_r : bit_r;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      bit_r <= 1'b0;
    end else begin
      s1_r <= raw_bit;
      s2_r <= s1_r;
      s3_r <= s2_r;
      bit_r <= bit_nxt;
    end
  end
  assign bit_new = bit_nxt;
  // ========================================================================
  // Total failure test: raw value stuck too long
  logic [STUCK_CNT_W-1:0] run_r, run_nxt;  // Current run length
  logic prev_r;  // Previous accepted bit
  logic tot_fail;
  // Run length, held at the limit only while the value stays put
  always_comb begin
    run_nxt = (bit_new == prev_r) ? run_r + 1'b1 : '0;
    if ((run_r == STUCK_CNT_W'(STUCK_CYC)) && (bit_new == prev_r)) run_nxt = run_r;  // RULE_02
  end
  assign tot_fail = (run_r == STUCK_CNT_W'(STUCK_CYC));  // RULE_01 RULE_02
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      run_r <= '0;
      prev_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      prev_r <= bit_new;
    end
  end
  // ========================================================================
  // Online test: ones count over each window, always running
  logic [WIN_CNT_W-1:0] pos_r, pos_nxt;  // Position in window
  logic [WIN_CNT_W-1:0] ones_r, ones_nxt;  // Ones so far
  logic [WIN_CNT_W-1:0] ones_fin;  // Ones including this bit
  logic win_end;
  logic win_bad;
  assign ones_fin = ones_r + WIN_CNT_W'(bit_new);
  assign win_end = (pos_r == WIN_LAST);  // RULE_05
  assign win_bad = win_end && ((ones_fin < ONES_LO) || (ones_fin > ONES_HI));  // RULE_03
  always_comb begin
    pos_nxt = win_end ? '0 : pos_r + 1'b1;
    ones_nxt = win_end ? '0 : ones_fin;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pos_r <= '0;
      ones_r <= '0;
    end else begin
      pos_r <= pos_nxt;
      ones_r <= ones_nxt;
    end
  end
  // ========================================================================
  // Health state and sticky alarm
  prg_state_t st_r, st_nxt;
  logic fault;
  logic alarm_nxt;
  logic healthy_nxt;
  assign fault = tot_fail || win_bad;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PRG_STARTUP: begin
        // Need one clean window end; after a fault that window began before start-up
        if (fault) st_nxt = PRG_FAULT;  // RULE_01
        else if (win_end) st_nxt = PRG_RUN;  // RULE_04
      end
      PRG_RUN: begin
        if (fault) st_nxt = PRG_FAULT;  // RULE_04
      end
      PRG_FAULT: begin
        // Retest in start-up; window and run counters keep running, not restarted
        st_nxt = PRG_STARTUP;
      end
      default: st_nxt = PRG_STARTUP;
    endcase
    // Set wins over clear
    alarm_nxt = fault ? 1'b1 : (alarm_clr ? 1'b0 : alarm_r);  // RULE_08
    healthy_nxt = (st_nxt == PRG_RUN);
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= PRG_STARTUP;
      alarm_r <= 1'b0;
      healthy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      alarm_r <= alarm_nxt;
      healthy_r <= healthy_nxt;
    end
  end
  // ========================================================================
  // Word assembly, raw bits unprocessed
  logic [WORD_W-1:0] sh_r, sh_nxt;  // Shift register
  logic [4:0] nb_r, nb_nxt;  // Bits gathered
  logic wide_r, wide_nxt;  // Format of word in progress
  logic kill;  // Discard in-flight words
  logic word_done;
  prg_word_t fin_word;
  logic fin_ready;
  prg_word_t fo_word;
  logic fo_valid;
  logic fo_ready;
  assign kill = fault || (st_r != PRG_RUN);  // RULE_02
  assign word_done = (nb_r == (wide_r ? 5'(WORD_W) : 5'(NARROW_W)));  // RULE_06
  assign fin_word.wide = wide_r;
  assign fin_word.data = wide_r ? sh_r : {8'h00, sh_r[NARROW_W-1:0]};  // RULE_06 RULE_07
  always_comb begin
    sh_nxt = sh_r;
    nb_nxt = nb_r;
    wide_nxt = wide_r;
    if (kill) begin
      // Partial word may hold post-failure bits
      nb_nxt = '0;
      wide_nxt = wide_mode;
    end else if (word_done) begin
      // Wait until the buffer takes it
      if (fin_ready) begin
        nb_nxt = '0;
        wide_nxt = wide_mode;
      end
    end else begin
      sh_nxt = {sh_r[WORD_W-2:0], bit_new};  // RULE_07
      nb_nxt = nb_r + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sh_r <= '0;
      nb_r <= '0;
      wide_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      nb_r <= nb_nxt;
      wide_r <= wide_nxt;
    end
  end
  // ========================================================================
  // Buffer, flushed on any fault
  prg_fifo #(
    .W(PW_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .flush(kill),  // RULE_02
    .in_data(fin_word),
    .in_valid(word_done && !kill),
    .in_ready(fin_ready),
    .out_data(fo_word),
    .out_valid(fo_valid),
    .out_ready(fo_ready)
  );

  // ========================================================================
  // Output register stage
  logic ov_nxt;
  logic [WORD_W-1:0] od_nxt;
  logic ow_nxt;

  assign fo_ready = !kill && (!rnd_valid_r || rnd_ready);

  always_comb begin
    ov_nxt = rnd_valid_r;
    od_nxt = rnd_data_r;
    ow_nxt = rnd_wide_r;
    if (kill) begin
      ov_nxt = 1'b0;  // RULE_04 RULE_08
    end else if (!rnd_valid_r || rnd_ready) begin
      ov_nxt = fo_valid;
      if (fo_valid) begin
        od_nxt = fo_word.data;
        ow_nxt = fo_word.wide;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rnd_valid_r <= 1'b0;
      rnd_data_r <= '0;
      rnd_wide_r <= 1'b0;
    end else begin
      rnd_valid_r <= ov_nxt;
      rnd_data_r <= od_nxt;
      rnd_wide_r <= ow_nxt;
    end
  end
endmodule

// File: prg_health_checker.sv
`timescale 1ns/1ps
// ==========
// Stream and health checker
module prg_health_checker
  import prg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Watched pins
  input wire logic raw_bit,
  input wire logic alarm_clr,
  input wire logic [WORD_W-1:0] rnd_data_r,
  input wire logic rnd_wide_r,
  input wire logic rnd_valid_r,
  input wire logic rnd_ready,
  input wire logic alarm_r,
  input wire logic healthy_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic raw_q_r, raw_q_nxt; // Last raw sample
  logic [7:0] run_r, run_nxt; // Equal raw samples in a row
  logic [8:0] age_r, age_nxt; // Cycles since reset, saturating
  // Next run length and age
  always_comb begin
    raw_q_nxt = raw_bit;
    run_nxt = (raw_bit != raw_q_r) ? 8'h00 : run_r + {7'h00, run_r != 8'hff};
    age_nxt = age_r + {8'h00, !age_r[8]};
  end
  // Register helpers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      raw_q_r <= 1'b0;
      run_r <= 8'h00;
      age_r <= 9'h000;
    end else begin
      raw_q_r <= raw_q_nxt;
      run_r <= run_nxt;
      age_r <= age_nxt;
    end
  end
  // Output fully blocked
  sequence s_blocked;
    alarm_r && !healthy_r && !rnd_valid_r;
  endsequence
  // Offered word unchanged
  sequence s_held;
    rnd_valid_r && $stable(rnd_data_r) && $stable(rnd_wide_r);
  endsequence
  a_stuck_alarm: assert property (run_r >= 8'h88 |-> s_blocked)
    else $error("stuck source not blocked");
  a_fault_blocks: assert property ($fell(healthy_r) |-> !rnd_valid_r [*8])
    else $error("word after fault");
  a_startup_window: assert property ($rose(healthy_r) |-> age_r[8])
    else $error("healthy before full window");
  a_valid_healthy: assert property (rnd_valid_r |-> healthy_r)
    else $error("word while unhealthy");
  a_word_holds: assert property (rnd_valid_r && !rnd_ready |=> !healthy_r or s_held)
    else $error("word changed before take");
  a_narrow_zero: assert property (rnd_valid_r && !rnd_wide_r |-> rnd_data_r[15:8] == 8'h00)
    else $error("narrow word upper byte set");
  a_alarm_sticky: assert property (alarm_r && !alarm_clr |=> alarm_r)
    else $error("alarm dropped");
  a_alarm_clear: assert property (alarm_r && alarm_clr && healthy_r |=> !alarm_r || !healthy_r)
    else $error("alarm not cleared");
endmodule

bind prg_health_gate prg_health_checker prg_health_checker_inst (.ref_clk, .sys_rst, .raw_bit,
  .alarm_clr, .rnd_data_r, .rnd_wide_r, .rnd_valid_r, .rnd_ready, .alarm_r, .healthy_r);

// File: prg_consumer.sv
`timescale 1ns/1ps
// ==========
// Consumer of the word stream
module prg_consumer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pacing
  input wire logic hold,
  input wire logic slow,
  // Stream
  output logic rnd_ready
);
  logic tick_r, tick_nxt; // Half-rate phase
  always_comb begin
    tick_nxt = !tick_r;
  end
  always_ff @(posedge ref_clk) begin
    tick_r <= sys_rst ? 1'b0 : tick_nxt;
  end
  // Stalled on hold, every other cycle when slow
  assign rnd_ready = !hold && (!slow || tick_r);
endmodule

// File: prg_health_gate_tb_top.sv
`timescale 1ns/1ps
// ==========
// Health-gated source bench
module prg_health_gate_tb_top
  import prg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic raw_bit = 1'b0; // Entropy pin
  logic wide_mode = 1'b0;
  logic alarm_clr = 1'b0;
  logic hold = 1'b0; // Consumer stall
  logic slow = 1'b0; // Consumer half rate
  logic [WORD_W-1:0] rnd_data_r;
  logic rnd_wide_r, rnd_valid_r, rnd_ready, alarm_r, healthy_r;
  logic [7:0] idx = 8'h00; // Pattern phase
  int pat = 0; // 0 balanced, 1 sparse, 2 stuck
  int mismatches = 0;
  int num_checks = 0;

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Raw pattern, period 8 when balanced
  always @(posedge ref_clk) begin
    idx <= idx + 8'h01;
    raw_bit <= (pat == 0) ? idx[2] : (pat == 1) ? (idx[4:2] == 3'h0) : 1'b0;
  end
  prg_health_gate prg_health_gate_inst (.ref_clk, .sys_rst, .raw_bit, .wide_mode, .alarm_clr,
    .rnd_data_r, .rnd_wide_r, .rnd_valid_r, .rnd_ready, .alarm_r, .healthy_r);
  prg_consumer prg_consumer_inst (.ref_clk, .sys_rst, .hold, .slow, .rnd_ready);

  task print_verdict;
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task step;
    @(posedge ref_clk);
    #1;
  endtask
  task check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  // Wait on healthy (0), alarm (1) or a take (2)
  task wait_for(input int sel, input logic want, input int bound);
    int n;
    n = 0;
    while (n < bound && (sel == 0 ? healthy_r : sel == 1 ? alarm_r : rnd_valid_r & rnd_ready) !== want) begin
      step;
      n++;
    end
    check(n < bound, "wait ran out");
    if (n >= bound) print_verdict;
  endtask
  task t_startup;
    logic seen;
    seen = 1'b0;
    repeat (250) begin
      step;
      seen = seen | rnd_valid_r | healthy_r;
    end
    check(seen === 1'b0, "word before start-up");
    wait_for(0, 1'b1, 700);
    check(alarm_r === 1'b0, "alarm on clean start");
  endtask
  // Words of one width; older ones skipped
  task t_words(input logic w, input logic s);
    @(posedge ref_clk);
    wide_mode <= w;
    slow <= s;
    for (int k = 0; k < 6; k++) begin
      wait_for(2, 1'b1, 200);
      if (k > 2) begin
        check(rnd_wide_r === w, "width flag");
        check((^rnd_data_r !== 1'bx) && $countones(rnd_data_r) == (w ? 8 : 4), "word bits");
      end
      step;
    end
  endtask
  // Fill under stall, then drain back to back
  task t_fill;
    int n;
    @(posedge ref_clk);
    hold <= 1'b1;
    slow <= 1'b0;
    repeat (600) step;
    check(rnd_valid_r === 1'b1, "nothing buffered");
    @(posedge ref_clk);
    hold <= 1'b0;
    step;
    n = 0;
    while (n < 40 && rnd_valid_r === 1'b1) begin
      step;
      n++;
    end
    check(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 4, "drain burst");
  endtask
  task t_fault(input int p, input int bound);
    @(posedge ref_clk);
    pat <= p;
    wait_for(1, 1'b1, bound);
    check(healthy_r === 1'b0 && rnd_valid_r === 1'b0, "fault not blocking");
  endtask
  task t_clear(input logic keep);
    @(posedge ref_clk);
    alarm_clr <= 1'b1;
    @(posedge ref_clk);
    alarm_clr <= 1'b0;
    #1;
    check(alarm_r === keep, "alarm clear");
  endtask
  task t_recover;
    @(posedge ref_clk);
    pat <= 0;
    wait_for(0, 1'b1, 900);
    check(alarm_r === 1'b1, "alarm not sticky");
    t_clear(1'b0);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_startup;
    t_words(1'b0, 1'b0);
    t_words(1'b1, 1'b1);
    t_fill;
    t_fault(1, 540);
    t_recover;
    t_fault(2, 150);
    t_clear(1'b1);
    t_recover;
    print_verdict;
  end
endmodule
